// ### far_side_model.sv
/*
 * Far side of the timer: quadrature encoder, hall sensors and a watch on the
 * power stage legs. Assumes active-high channel outputs (polarity 0).
 */
`timescale 1ns/1ps
module far_side_model (
    input wire logic mclk_i,
    input wire logic fwd_i,
    input wire logic rev_i,
    input wire logic [2:0] hall_set_i,
    input wire logic [2:0] ch_i,
    input wire logic [2:0] ch_n_i,
    output logic enc_a_o,
    output logic enc_b_o,
    output logic [2:0] hall_o,
    output logic overlap_o
);
    logic [1:0] phase;

    // gray-coded quadrature levels, one phase step per request
    assign enc_a_o = phase[0] ^ phase[1];
    assign enc_b_o = phase[1];

    initial begin
        phase = 2'h0;
        hall_o = 3'h0;
        overlap_o = 1'b0;
    end

    // step the encoder, follow the hall levels, latch any shoot-through
    always @(posedge mclk_i) begin
        phase <= phase + {1'b0, fwd_i} - {1'b0, rev_i};
        hall_o <= hall_set_i;
        // both switches of a leg on
        if ((ch_i & ch_n_i) != 3'h0) overlap_o <= 1'b1;
    end
endmodule : far_side_model

// ### multichannel_pwm_capture_timer.sv
/*
 * Multichannel PWM / capture timer: prescaled 16-bit counter, four
 * capture/compare channels, complementary outputs with dead time on the
 * advanced variant, encoder and hall inputs, trigger link, DMA and
 * converter trigger outputs. Configuration arrives as static inputs from
 * the surrounding logic; all inputs are synchronous to mclk_i.
 */
// Summary of operation
// - 16-bit reloading counter counts up, down or up/down.
// - prescaler divides the counter clock by any factor 1 to 65536.
// - four channels each do capture, compare, PWM or one-pulse output.
// - advanced variant drives three complementary pairs with dead time.
// - advanced PWM covers the full duty range, 0 to 100 percent.
// - advanced variant freezes counter and forces outputs inactive in debug halt.
// - general variant holds its counter during debug halt.
// - trigger link lets one timer start, reset or chain another.
// - each timer raises its own DMA request lines.
// - general variant decodes quadrature encoders and one to three hall sensors.
// - timer events route to converter regular, injected and DMA triggers.
`timescale 1ns/1ps
module multichannel_pwm_capture_timer #(
    parameter bit ADVANCED = 1'b1
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire timer_pkg::cfg_t cfg_i,
    input wire timer_pkg::ch_cfg_t [3:0] ch_cfg_i,
    input wire logic [3:0] ch_in_i,
    input wire logic enc_a_i,
    input wire logic enc_b_i,
    input wire logic [2:0] hall_i,
    input wire logic trig_i,
    input wire logic debug_halt_i,
    output logic [15:0] cnt_o,
    output logic [3:0][15:0] capture_o,
    output logic [3:0] ch_o,
    output logic [2:0] ch_n_o,
    output logic update_o,
    output logic trig_o,
    output logic [4:0] dma_o,
    output logic adc_reg_o,
    output logic adc_inj_o,
    output logic adc_dma_o
);
    // pick one event from the event vector, unknown codes give none
    function automatic logic pick_event(input logic [5:0] ev, input logic [2:0] sel);
        pick_event = (sel < 3'(timer_pkg::NUM_EV)) ? ev[sel] : 1'b0;
    endfunction : pick_event

    logic [15:0] cnt;
    logic [15:0] psc;
    logic dir_down;
    logic running;
    logic en_prev;
    logic trig_prev;
    logic enc_a_prev;
    logic enc_b_prev;
    logic hall_prev;
    logic cnt_moved;
    logic [3:0] in_prev;
    logic [3:0] cmp_ref;
    logic [3:0] ref_d;
    logic [2:0][7:0] dt_cnt;
    logic [15:0] next_cnt;
    logic next_dir;
    logic upd;
    logic [3:0] ref_now;
    logic [3:0] ch_edge;
    logic [3:0] ch_ev;
    logic [3:0] main_act;
    logic [2:0] comp_act;
    logic [3:0] pol;

    // debug halt, trigger link and encoder decoding
    wire halt = debug_halt_i & cfg_i.dbg_freeze;
    wire force_off = ADVANCED & debug_halt_i & cfg_i.dbg_out_off;
    wire trig_edge = trig_i & ~trig_prev;
    wire trig_reset = trig_edge & (cfg_i.slave_mode == timer_pkg::SLAVE_RESET);
    wire trig_start = trig_edge & (cfg_i.slave_mode == timer_pkg::SLAVE_START);
    wire enc_step = (enc_a_i ^ enc_a_prev) | (enc_b_i ^ enc_b_prev);
    wire enc_down = enc_a_prev ^ enc_b_i;
    wire hall_x = ^hall_i;
    wire psc_hit = (psc == cfg_i.prescale);
    wire at_top = (cnt == cfg_i.reload);
    wire at_zero = (cnt == timer_pkg::CNT_RESET);
    wire step = running & ~halt & (cfg_i.encoder_en ? enc_step : psc_hit);
    wire set_run = cfg_i.enable & ((~en_prev & cfg_i.slave_mode != timer_pkg::SLAVE_START)
        | trig_start);
    wire clr_run = ~cfg_i.enable | (cfg_i.one_pulse & upd);
    wire [5:0] events = {trig_edge, ch_ev, upd};

    // prescaler divides by prescale plus one
    wire [15:0] next_psc = (~running | halt | psc_hit | trig_reset) ? (psc_hit | trig_reset ?
        timer_pkg::PSC_RESET : psc) : psc + 16'h0001;

    always_comb begin
        next_cnt = cnt;
        next_dir = dir_down;
        upd = 1'b0;
        if (trig_reset) begin
            next_cnt = (cfg_i.count_mode == timer_pkg::CNT_DOWN) ? cfg_i.reload
                : timer_pkg::CNT_RESET;
            next_dir = 1'b0;
            upd = 1'b1;
        end else if (step && cfg_i.encoder_en) begin
            if (enc_down) begin
                next_cnt = at_zero ? cfg_i.reload : cnt - 16'h0001;
            end else begin
                next_cnt = at_top ? timer_pkg::CNT_RESET : cnt + 16'h0001;
            end
        end else if (step) begin
            // reload and update at the turning points
            case (cfg_i.count_mode)
                timer_pkg::CNT_UP: begin
                    next_cnt = at_top ? timer_pkg::CNT_RESET : cnt + 16'h0001;
                    upd = at_top;
                end
                timer_pkg::CNT_DOWN: begin
                    next_cnt = at_zero ? cfg_i.reload : cnt - 16'h0001;
                    upd = at_zero;
                end
                timer_pkg::CNT_CENTER: begin
                    if (!dir_down) begin
                        next_cnt = at_top ? cnt - 16'h0001 : cnt + 16'h0001;
                        next_dir = at_top;
                        upd = at_top;
                    end else begin
                        next_cnt = at_zero ? cnt + 16'h0001 : cnt - 16'h0001;
                        next_dir = ~at_zero;
                        upd = at_zero;
                    end
                end
                default: begin
                    next_cnt = cnt;
                end
            endcase
        end
    end

    // per-channel capture edge, compare event and reference waveform
    always_comb begin
        for (int k = 0; k < timer_pkg::NUM_CH; k++) begin
            pol[k] = ch_cfg_i[k].polarity;
            ch_edge[k] = ch_cfg_i[k].polarity ? (in_prev[k] & ~ch_in_i[k])
                : (~in_prev[k] & ch_in_i[k]);
            ch_ev[k] = (ch_cfg_i[k].mode == timer_pkg::CH_CAPTURE) ? ch_edge[k]
                : (cnt_moved & cnt == ch_cfg_i[k].compare);
            case (ch_cfg_i[k].mode)
                timer_pkg::CH_COMPARE: ref_now[k] = cmp_ref[k];
                // compare 0 stays low, compare above reload stays high
                timer_pkg::CH_PWM: ref_now[k] = (cnt < ch_cfg_i[k].compare);
                timer_pkg::CH_ONE_PULSE: ref_now[k] = running & (cnt >= ch_cfg_i[k].compare);
                default: ref_now[k] = 1'b0;
            endcase
        end
        // hall sensor change captures on channel 0
        if (cfg_i.hall_en) begin
            ch_edge[0] = (hall_x != hall_prev);
            ch_ev[0] = ch_edge[0];
        end
    end

    // dead time gap between true and complementary outputs
    always_comb begin
        for (int k = 0; k < timer_pkg::NUM_CH; k++) begin
            main_act[k] = ref_d[k];
        end
        for (int k = 0; k < timer_pkg::NUM_PAIRS; k++) begin
            comp_act[k] = 1'b0;
            if (ADVANCED) begin
                main_act[k] = ref_d[k] & (dt_cnt[k] == timer_pkg::DT_RESET)
                    & (ref_now[k] == ref_d[k]);
                comp_act[k] = ~ref_d[k] & (dt_cnt[k] == timer_pkg::DT_RESET)
                    & (ref_now[k] == ref_d[k]);
            end
        end
    end

    // counter, prescaler and run control
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            cnt <= timer_pkg::CNT_RESET;
            psc <= timer_pkg::PSC_RESET;
            dir_down <= 1'b0;
            running <= 1'b0;
            en_prev <= 1'b0;
            cnt_moved <= 1'b0;
        end else begin
            cnt <= next_cnt;
            psc <= next_psc;
            dir_down <= next_dir;
            // start on link trigger or enable
            running <= set_run | (running & ~clr_run);
            en_prev <= cfg_i.enable;
            cnt_moved <= step | trig_reset;
        end
    end

    // input history registers
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            trig_prev <= 1'b0;
            enc_a_prev <= 1'b0;
            enc_b_prev <= 1'b0;
            hall_prev <= 1'b0;
            in_prev <= 4'h0;
        end else begin
            trig_prev <= trig_i;
            enc_a_prev <= enc_a_i;
            enc_b_prev <= enc_b_i;
            hall_prev <= hall_x;
            in_prev <= ch_in_i;
        end
    end

    // channel state, captures and pin drivers
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            capture_o <= '0;
            cmp_ref <= 4'h0;
            ref_d <= 4'h0;
            dt_cnt <= '0;
            ch_o <= 4'h0;
            ch_n_o <= 3'h0;
        end else begin
            ref_d <= ref_now;
            for (int k = 0; k < timer_pkg::NUM_CH; k++) begin
                if (ch_edge[k] && (ch_cfg_i[k].mode == timer_pkg::CH_CAPTURE
                    || (k == 0 && cfg_i.hall_en))) begin
                    capture_o[k] <= cnt;
                end
                if (ch_ev[k] && ch_cfg_i[k].mode == timer_pkg::CH_COMPARE) begin
                    cmp_ref[k] <= ~cmp_ref[k];
                end
                // debug halt with dbg_out_off on the advanced variant drives every output to its idle level
                ch_o[k] <= (force_off | ~ch_cfg_i[k].out_en) ? pol[k] : main_act[k] ^ pol[k];
            end
            for (int k = 0; k < timer_pkg::NUM_PAIRS; k++) begin
                if (ref_now[k] != ref_d[k]) begin
                    dt_cnt[k] <= cfg_i.dead_time;
                end else if (dt_cnt[k] != timer_pkg::DT_RESET) begin
                    dt_cnt[k] <= dt_cnt[k] - 8'h01;
                end
                ch_n_o[k] <= (force_off | ~ch_cfg_i[k].out_en | ~ADVANCED) ? pol[k]
                    : comp_act[k] ^ pol[k];
            end
        end
    end

    // event pulses: update, link, DMA and converter triggers
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            update_o <= 1'b0;
            trig_o <= 1'b0;
            dma_o <= 5'h00;
            adc_reg_o <= 1'b0;
            adc_inj_o <= 1'b0;
            adc_dma_o <= 1'b0;
        end else begin
            update_o <= upd;
            trig_o <= upd;
            // own DMA requests, update and channels
            dma_o <= cfg_i.dma_en & {ch_ev, upd};
            adc_reg_o <= pick_event(events, cfg_i.adc_reg_sel);
            adc_inj_o <= pick_event(events, cfg_i.adc_inj_sel);
            adc_dma_o <= pick_event(events, cfg_i.adc_dma_sel);
        end
    end

    assign cnt_o = cnt;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    property p_prescale;
        ($changed(cnt) && !$past(rst_i)) |-> $past(psc_hit | trig_reset | cfg_i.encoder_en);
    endproperty
    a_prescale: assert property (p_prescale) else $error("counter moved without prescaler tick");
    property p_up_wrap;
        (step && !trig_reset && !cfg_i.encoder_en && cfg_i.count_mode == timer_pkg::CNT_UP
            && at_top) |=> (cnt == 16'h0000) && update_o;
    endproperty
    a_up_wrap: assert property (p_up_wrap) else $error("up count did not wrap with update");
    property p_down_reload;
        (step && !trig_reset && !cfg_i.encoder_en && cfg_i.count_mode == timer_pkg::CNT_DOWN
            && at_zero) |=> (cnt == $past(cfg_i.reload)) && update_o;
    endproperty
    a_down_reload: assert property (p_down_reload) else $error("down count did not reload");
    property p_freeze;
        (halt && !trig_reset) |=> $stable(cnt);
    endproperty
    a_freeze: assert property (p_freeze) else $error("counter moved during debug halt");
    property p_debug_off;
        force_off |=> (ch_o == $past(pol)) && (ch_n_o == $past(pol[2:0]));
    endproperty
    a_debug_off: assert property (p_debug_off) else $error("outputs active during debug halt");
    property p_no_overlap;
        ((ch_o[2:0] ^ pol[2:0]) & (ch_n_o ^ pol[2:0])) == 3'h0 || $changed(pol);
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("pair outputs active together");
    property p_zero_duty;
        (ch_cfg_i[0].mode == timer_pkg::CH_PWM && ch_cfg_i[0].compare == 16'h0000)[*2]
            |=> ch_o[0] == $past(pol[0]);
    endproperty
    a_zero_duty: assert property (p_zero_duty) else $error("zero duty output went active");
    property p_capture;
        (ch_edge[1] && ch_cfg_i[1].mode == timer_pkg::CH_CAPTURE) |=> capture_o[1] == $past(cnt);
    endproperty
    a_capture: assert property (p_capture) else $error("capture missed counter value");
    property p_link;
        upd |=> trig_o && update_o;
    endproperty
    a_link: assert property (p_link) else $error("update not sent on link");
    property p_dma;
        (upd && cfg_i.dma_en[0]) |=> dma_o[0];
    endproperty
    a_dma: assert property (p_dma) else $error("update DMA request missing");
    property p_adc;
        (upd && cfg_i.adc_reg_sel == timer_pkg::EV_UPDATE) |=> adc_reg_o;
    endproperty
    a_adc: assert property (p_adc) else $error("converter trigger missing");
    property p_encoder;
        (step && cfg_i.encoder_en && !trig_reset && !enc_down && !at_top)
            |=> cnt == $past(cnt) + 16'h0001;
    endproperty
    a_encoder: assert property (p_encoder) else $error("encoder step not counted");

    c_update: cover property (update_o);
    c_capture: cover property (ch_edge[0] && ch_cfg_i[0].mode == timer_pkg::CH_CAPTURE);
    c_trig_start: cover property (trig_start ##1 running);
    c_center_turn: cover property (cfg_i.count_mode == timer_pkg::CNT_CENTER && upd && dir_down);
endmodule : multichannel_pwm_capture_timer

// ### multichannel_pwm_capture_timer_test.sv
/*
 * Self-checking bench of the multichannel timer: counting modes, debug halt,
 * PWM extremes and dead time, capture, encoder, hall and trigger link.
 * Assumes the far side model and the timer package are compiled first.
 */
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin bad_count++; \
    $display("FAIL %0t value mismatch", $time); end end
module multichannel_pwm_capture_timer_test;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    timer_pkg::cfg_t cfg = '0;
    timer_pkg::ch_cfg_t [3:0] ch_cfg = '0;
    logic [3:0] ch_in_i = 4'h0;
    logic trig_i = 1'b0;
    logic debug_halt_i = 1'b0;
    logic fwd = 1'b0;
    logic rev = 1'b0;
    logic [2:0] hall_set = 3'h0;
    logic enc_a, enc_b, update_o, trig_o, adc_reg_o, adc_inj_o, adc_dma_o, overlap;
    logic [2:0] hall, ch_n_o;
    logic [3:0] ch_o;
    logic [4:0] dma_o;
    logic [15:0] cnt_o, v;
    logic [3:0][15:0] capture_o;
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int n, k;

    multichannel_pwm_capture_timer uut (.mclk_i(mclk_i), .rst_i(rst_i), .cfg_i(cfg),
        .ch_cfg_i(ch_cfg), .ch_in_i(ch_in_i), .enc_a_i(enc_a), .enc_b_i(enc_b),
        .hall_i(hall), .trig_i(trig_i), .debug_halt_i(debug_halt_i), .cnt_o(cnt_o),
        .capture_o(capture_o), .ch_o(ch_o), .ch_n_o(ch_n_o), .update_o(update_o),
        .trig_o(trig_o), .dma_o(dma_o), .adc_reg_o(adc_reg_o), .adc_inj_o(adc_inj_o),
        .adc_dma_o(adc_dma_o));
    far_side_model partner (.mclk_i(mclk_i), .fwd_i(fwd), .rev_i(rev), .hall_set_i(hall_set),
        .ch_i(ch_o[2:0]), .ch_n_i(ch_n_o), .enc_a_o(enc_a), .enc_b_o(enc_b), .hall_o(hall),
        .overlap_o(overlap));

    // 50 MHz clock and hang guard
    always #10 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            results();
        end
    end

    task automatic tick(input int c);
        repeat (c) @(posedge mclk_i);
        #1;
    endtask : tick

    // apply the staged configuration through a short reset
    task automatic restart;
        @(posedge mclk_i);
        rst_i <= 1'b1;
        @(posedge mclk_i);
        rst_i <= 1'b0;
    endtask : restart

    task automatic wait_upd(output int c);
        c = 0;
        do begin
            tick(1);
            c++;
        end while (update_o !== 1'b1 && c < 300);
    endtask : wait_upd

    // period of the update event in every count mode and two prescales
    task automatic test_period;
        timer_pkg::count_mode_t m;
        int exp;
        for (int i = 0; i < 6; i++) begin
            m = timer_pkg::count_mode_t'(i % 3);
            @(posedge mclk_i);
            cfg <= '0;
            cfg.enable <= 1'b1;
            cfg.count_mode <= m;
            cfg.prescale <= 16'(i / 3);
            cfg.reload <= 16'h0003;
            cfg.dma_en <= 5'h01;
            cfg.adc_reg_sel <= timer_pkg::EV_UPDATE;
            cfg.adc_dma_sel <= 3'h7;
            restart();
            wait_upd(n);
            wait_upd(n);
            exp = (m == timer_pkg::CNT_CENTER) ? 3 * (i / 3 + 1) : 4 * (i / 3 + 1);
            `CHK(n, exp) // divide by prescale plus one
            v = (m == timer_pkg::CNT_UP) ? 16'h0000 : 16'h0003;
            if (m != timer_pkg::CNT_CENTER) `CHK(cnt_o, v) // wrap value
            `CHK({trig_o, dma_o[0], adc_reg_o, adc_dma_o}, 4'hE) // update event routing
        end
        $display("test period done");
    endtask : test_period

    // debug halt freezes the counter and forces the outputs off
    task automatic test_debug;
        @(posedge mclk_i);
        cfg <= '0;
        cfg.enable <= 1'b1;
        cfg.reload <= 16'hFFFF;
        cfg.dbg_freeze <= 1'b1;
        cfg.dbg_out_off <= 1'b1;
        ch_cfg[0] <= '{timer_pkg::CH_PWM, 16'h8000, 1'b0, 1'b1};
        restart();
        tick(6);
        `CHK({ch_o[0], ch_n_o[0]}, 2'h2) // pwm active below compare
        debug_halt_i <= 1'b1;
        tick(3);
        v = cnt_o;
        tick(5);
        `CHK(cnt_o, v) // counter frozen
        `CHK({ch_o[0], ch_n_o[0]}, 2'h0) // outputs forced inactive
        debug_halt_i <= 1'b0;
        tick(4);
        `CHK(cnt_o != v, 1'b1) // counting resumes
        $display("test debug done");
    endtask : test_debug

    // duty extremes and dead-time gaps
    task automatic test_pwm;
        int gap, low, high;
        @(posedge mclk_i);
        cfg <= '0;
        cfg.enable <= 1'b1;
        cfg.reload <= 16'h0007;
        cfg.dead_time <= 8'h02;
        ch_cfg[0] <= '{timer_pkg::CH_PWM, 16'h0004, 1'b0, 1'b1};
        ch_cfg[1] <= '{timer_pkg::CH_PWM, 16'h0000, 1'b0, 1'b1};
        ch_cfg[2] <= '{timer_pkg::CH_PWM, 16'h0008, 1'b0, 1'b1};
        restart();
        tick(12);
        gap = 0;
        low = 0;
        high = 0;
        for (int i = 0; i < 16; i++) begin
            tick(1);
            gap += int'(ch_o[0] == 1'b0 && ch_n_o[0] == 1'b0);
            low += int'(ch_o[1] == 1'b1);
            high += int'(ch_o[2] == 1'b1 && ch_n_o[2] == 1'b0);
        end
        `CHK(gap, 12) // gap of one plus dead time per edge
        `CHK(low, 0) // zero duty
        `CHK(high, 16) // full duty
        `CHK(overlap, 1'b0) // never both active
        $display("test pwm done");
    endtask : test_pwm

    // capture of a stopped counter
    task automatic test_capture;
        @(posedge mclk_i);
        cfg <= '0;
        cfg.enable <= 1'b1;
        cfg.reload <= 16'hFFFF;
        cfg.dma_en <= 5'h1F;
        ch_cfg <= '0;
        restart();
        tick(9);
        cfg.enable <= 1'b0;
        tick(3);
        v = cnt_o;
        ch_in_i[0] <= 1'b1;
        k = 0;
        for (int i = 0; i < 4; i++) begin
            tick(1);
            k += int'(dma_o[1] === 1'b1);
        end
        `CHK(capture_o[0], v) // captured counter value
        `CHK(k, 1) // one request per capture
        ch_in_i[0] <= 1'b0;
        $display("test capture done");
    endtask : test_capture

    // quadrature steps forward, back through zero, then a hall change
    task automatic test_encoder;
        @(posedge mclk_i);
        cfg <= '0;
        cfg.enable <= 1'b1;
        cfg.reload <= 16'hFFFF;
        cfg.encoder_en <= 1'b1;
        cfg.hall_en <= 1'b1;
        restart();
        tick(3);
        for (int i = 0; i < 10; i++) begin
            fwd <= (i < 4);
            rev <= (i >= 4);
            tick(1);
            fwd <= 1'b0;
            rev <= 1'b0;
            tick(3);
            if (i == 3) `CHK(cnt_o, 16'h0004) // forward count
        end
        `CHK(cnt_o, 16'hFFFE) // reverse wraps at zero
        hall_set <= 3'h1;
        tick(5);
        `CHK(capture_o[0], 16'hFFFE) // hall change captures
        $display("test encoder done");
    endtask : test_encoder

    // link trigger restarts the count
    task automatic test_trigger;
        @(posedge mclk_i);
        cfg <= '0;
        cfg.enable <= 1'b1;
        cfg.reload <= 16'hFFFF;
        cfg.slave_mode <= timer_pkg::SLAVE_RESET;
        restart();
        tick(30);
        trig_i <= 1'b1;
        wait_upd(n);
        `CHK(n <= 3, 1'b1) // update follows the trigger
        `CHK(cnt_o < 16'h0004, 1'b1) // counter restarted
        trig_i <= 1'b0;
        $display("test trigger done");
    endtask : test_trigger

    // start on link trigger, one-shot stop, compare toggle, injected trigger
    task automatic test_oneshot;
        int hi;
        @(posedge mclk_i);
        cfg <= '0;
        cfg.enable <= 1'b1;
        cfg.reload <= 16'h0005;
        cfg.one_pulse <= 1'b1;
        cfg.slave_mode <= timer_pkg::SLAVE_START;
        cfg.adc_inj_sel <= timer_pkg::EV_TRIG;
        ch_cfg[0] <= '{timer_pkg::CH_ONE_PULSE, 16'h0003, 1'b0, 1'b1};
        ch_cfg[2:1] <= '0;
        ch_cfg[3] <= '{timer_pkg::CH_COMPARE, 16'h0002, 1'b0, 1'b1};
        restart();
        tick(8);
        `CHK(cnt_o, 16'h0000) // waits for link trigger
        trig_i <= 1'b1;
        tick(1);
        `CHK(adc_inj_o, 1'b1) // injected trigger on link edge
        trig_i <= 1'b0;
        hi = 0;
        for (int i = 0; i < 12; i++) begin
            tick(1);
            hi += int'(ch_o[0] == 1'b1);
        end
        `CHK(hi, 2) // one-pulse width after one-cycle gap
        `CHK(cnt_o, 16'h0000) // one-shot stops after update
        `CHK(ch_o[3], 1'b1) // compare match toggles output
        $display("test oneshot done");
    endtask : test_oneshot

    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : results

    initial begin
        tick(19);
        `CHK({cnt_o, ch_o, ch_n_o, update_o}, 24'h000000) // quiet in reset
        @(posedge mclk_i);
        rst_i <= 1'b0;
        test_period();
        test_debug();
        test_pwm();
        test_capture();
        test_encoder();
        test_trigger();
        test_oneshot();
        results();
    end
endmodule : multichannel_pwm_capture_timer_test

// ### timer_pkg.sv
/*
 * Shared constants, modes and configuration carriers of the multichannel
 * PWM / capture timer. Assumes a single synchronous clock domain.
 */
package timer_pkg;
    localparam int CNT_W = 16;
    localparam int NUM_CH = 4;
    localparam int NUM_PAIRS = 3;
    localparam int NUM_EV = 6;
    localparam int NUM_DMA = 5;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] PSC_RESET = 16'h0000;
    localparam logic [7:0] DT_RESET = 8'h00;
    // event selector codes for the converter triggers
    localparam logic [2:0] EV_UPDATE = 3'h0;
    localparam logic [2:0] EV_CH0 = 3'h1;
    localparam logic [2:0] EV_TRIG = 3'h5;

    typedef enum logic [1:0] {CNT_UP, CNT_DOWN, CNT_CENTER} count_mode_t;
    typedef enum logic [1:0] {CH_CAPTURE, CH_COMPARE, CH_PWM, CH_ONE_PULSE} ch_mode_t;
    typedef enum logic [1:0] {SLAVE_OFF, SLAVE_RESET, SLAVE_START} slave_mode_t;

    typedef struct packed {
        logic enable;
        count_mode_t count_mode;
        logic one_pulse;
        logic [15:0] prescale;
        logic [15:0] reload;
        slave_mode_t slave_mode;
        logic dbg_freeze;
        logic dbg_out_off;
        logic encoder_en;
        logic hall_en;
        logic [7:0] dead_time;
        logic [2:0] adc_reg_sel;
        logic [2:0] adc_inj_sel;
        logic [2:0] adc_dma_sel;
        logic [4:0] dma_en;
    } cfg_t;

    typedef struct packed {
        ch_mode_t mode;
        logic [15:0] compare;
        logic polarity;
        logic out_en;
    } ch_cfg_t;
endpackage : timer_pkg
